//--- hdl/csp_top.sv
// Cascaded serial PWM generator: shift chain, latch/blank, correction, PWM outputs
// Function
// - Output high while counter below synced width
// - Pulse timed by counting PWM clock rises
// - Shift and PWM clocks handled independently
// - Serial out presents last chain stage
// - Shift clock out copies shift clock in
// - Shift clock rises step the chain; chain and multiplier both run on the system clock
// - Latch function asserted whenever pin high
// - Latch rise captures command in low byte
// - Multiplier results loaded into holding registers
// - Latch high loads status into chain
// - Pin high over 50us blanks and resets
// - Fault input reported in status flag
// - Self-test identifies faulty output
// - Frame is 48x12 channels plus command
// - Correction scales by (c+32)/96 unless disabled
// - Sync update at counter zero, async immediate
// - Outputs low until output enable command
`timescale 1ns/1ps
`default_nettype none
module csp_top
  import csp_pkg::*;
#(
  parameter int BLANK_CYCLES = BLANK_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial link
  input wire logic shift_clock_in,
  input wire logic serial_data_in,
  input wire logic latch_blank_pin,
  output logic shift_clock_out,
  output logic serial_data_out,
  // PWM timing and fault
  input wire logic pwm_clock_in,
  input wire logic string_fault_n,
  // PWM outputs
  output logic [CHANNELS-1:0] pwm_out
);
  localparam int BW = $clog2(BLANK_CYCLES + 1);
  localparam int DW = CHANNELS * WIDTH_BITS;

  logic sck_lv, sck_rise, sdi_lv, latch_lv, latch_rise;
  logic pwm_lv, pwm_rise, fault_n_lv;

  // Each outside input passes its own synchroniser
  csp_sync #(.RST_VAL(1'b0)) u_sck (.clk_sys(clk_sys), .rst(rst), .d(shift_clock_in),
    .lv(sck_lv), .rise(sck_rise));
  csp_sync #(.RST_VAL(1'b0)) u_sdi (.clk_sys(clk_sys), .rst(rst), .d(serial_data_in),
    .lv(sdi_lv), .rise());
  csp_sync #(.RST_VAL(1'b0)) u_lat (.clk_sys(clk_sys), .rst(rst), .d(latch_blank_pin),
    .lv(latch_lv), .rise(latch_rise));
  csp_sync #(.RST_VAL(1'b0)) u_pwm (.clk_sys(clk_sys), .rst(rst), .d(pwm_clock_in),
    .lv(pwm_lv), .rise(pwm_rise));
  csp_sync #(.RST_VAL(1'b1)) u_flt (.clk_sys(clk_sys), .rst(rst), .d(string_fault_n),
    .lv(fault_n_lv), .rise());

  // Blank detector: long latch pulse resets the core
  logic [BW-1:0] blank_q, blank_d;
  logic blank_act, core_rst;
  assign blank_act = (blank_q >= BW'(BLANK_CYCLES));
  assign core_rst = rst | blank_act;

  always_comb begin
    blank_d = '0;
    if (latch_lv) blank_d = blank_act ? blank_q : blank_q + 1'b1; // Saturates
  end

  always_ff @(posedge clk_sys) begin
    if (rst) blank_q <= '0;
    else blank_q <= blank_d;
  end

  // Core state
  logic [FRAME_BITS-1:0] chain_q, chain_d;
  logic [DW-1:0] frame_q, frame_d;
  logic [COR_BITS-1:0] cor_q [CHANNELS];
  logic [COR_BITS-1:0] cor_d [CHANNELS];
  logic [WIDTH_BITS-1:0] hold_q [CHANNELS];
  logic [WIDTH_BITS-1:0] hold_d [CHANNELS];
  logic [WIDTH_BITS-1:0] sync_q [CHANNELS];
  logic [WIDTH_BITS-1:0] sync_d [CHANNELS];
  logic [CHANNELS-1:0] mask_q, mask_d, pwm_q, pwm_d;
  logic [WIDTH_BITS-1:0] cnt_q, cnt_d;
  logic [IDX_BITS-1:0] idx_q, idx_d;
  csp_seq_t seq_q, seq_d;
  logic crd_q, crd_d, en_q, en_d, test_q, test_d;
  logic pend_q, pend_d, async_q, async_d, fault_q, fault_d;
  logic pace_q, pace_d, sck_out_q, sck_out_d;

  // Status frame: holding widths then status byte
  logic [DW-1:0] hold_flat;
  logic [CMD_BITS-1:0] status_byte;
  logic [CMD_BITS-1:0] cmd;
  assign cmd = chain_q[CMD_LSB +: CMD_BITS];

  always_comb begin
    hold_flat = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      hold_flat[i*WIDTH_BITS +: WIDTH_BITS] = hold_q[i];
    end
    status_byte = '0;
    status_byte[ST_FAULT] = fault_q | ~fault_n_lv;
    status_byte[ST_CRD] = crd_q;
    status_byte[ST_OUT_EN] = en_q;
    status_byte[ST_TEST] = test_q;
  end

  // Correction multiplier feeding the FIFO
  logic [WIDTH_BITS-1:0] push_raw, push_w;
  logic [IDX_BITS+WIDTH_BITS:0] prod;
  logic push_vld, push_rdy, pop_vld, pop_rdy, xfer;
  logic [FIFO_WIDTH-1:0] pop_data;

  always_comb begin
    push_raw = frame_q[idx_q*WIDTH_BITS +: WIDTH_BITS];
    prod = push_raw * (7'(cor_q[idx_q]) + 7'(COR_OFFSET));
    push_w = crd_q ? push_raw : WIDTH_BITS'(prod / COR_DIVISOR);
  end
  assign push_vld = (seq_q == SEQ_CALC);

  // Drain paced at half rate, so the FIFO really backs up
  assign pop_rdy = pace_q;

  csp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys), .rst(core_rst),
    .in_vld(push_vld), .in_rdy(push_rdy), .in_data({idx_q, push_w}),
    .out_vld(pop_vld), .out_rdy(pop_rdy), .out_data(pop_data));

  // Synced registers take holding values on update
  assign xfer = (seq_q == SEQ_DRAIN && !pop_vld && async_q) ||
                (pend_q && cnt_q == '0);

  always_comb begin
    chain_d = chain_q;
    frame_d = frame_q;
    cor_d = cor_q;
    hold_d = hold_q;
    sync_d = sync_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    seq_d = seq_q;
    crd_d = crd_q;
    en_d = en_q;
    test_d = test_q;
    pend_d = pend_q;
    async_d = async_q;
    fault_d = fault_q;
    pace_d = ~pace_q;
    sck_out_d = sck_lv;
    // Shift on each shift clock rise while latch is low
    if (sck_rise && !latch_lv) chain_d = {chain_q[FRAME_BITS-2:0], sdi_lv};
    // Latch high loads status; shift is ignored meanwhile
    if (latch_lv) begin
      chain_d = {hold_flat, status_byte};
    end
    // Reported flag clears only once the latch falls, so every status load sees it
    if (!latch_lv && blank_q != '0) fault_d = 1'b0;
    // Fault set wins over the clear above
    if (!fault_n_lv) fault_d = 1'b1;
    // Free-running counter on PWM clock rises
    if (pwm_rise) cnt_d = cnt_q + 1'b1;
    // Command decode on latch rise
    if (latch_rise) begin
      if (cmd == CMD_UPD_SYNC || cmd == CMD_UPD_ASYNC) begin
        frame_d = chain_q[FRAME_BITS-1:CMD_BITS];
        async_d = (cmd == CMD_UPD_ASYNC);
        idx_d = '0;
        seq_d = SEQ_CALC;
        pend_d = 1'b0;
        test_d = 1'b0;
      end else if (cmd == CMD_CORRECTION) begin
        for (int i = 0; i < CHANNELS; i++) begin
          cor_d[i] = chain_q[CMD_BITS + i*WIDTH_BITS +: COR_BITS];
        end
      end else if (cmd == CMD_OUT_ENABLE) begin
        en_d = 1'b1;
        if (!en_q) cnt_d = '0; // Period starts with the enable
      end else if (cmd == CMD_SELF_TEST) begin
        // Field MSB picks which outputs are forced on
        for (int i = 0; i < CHANNELS; i++) begin
          mask_d[i] = chain_q[CMD_BITS + i*WIDTH_BITS + WIDTH_BITS - 1];
        end
        test_d = 1'b1;
      end else if (cmd[7:4] == CMD_COR_TOGGLE_HI) begin
        crd_d = ~crd_q;
      end
    end
    // Sequencer: push 48 corrected widths, then wait for drain
    case (seq_q)
      SEQ_IDLE: seq_d = seq_d;
      SEQ_CALC: begin
        if (push_rdy) begin
          idx_d = idx_q + 1'b1;
          if (idx_q == IDX_BITS'(CHANNELS - 1)) seq_d = SEQ_DRAIN;
        end
      end
      SEQ_DRAIN: begin
        if (!pop_vld) begin
          seq_d = SEQ_IDLE;
          if (!async_q) pend_d = 1'b1;
        end
      end
      default: seq_d = SEQ_IDLE;
    endcase
    // Holding registers take multiplier results
    if (pop_vld && pop_rdy) begin
      hold_d[pop_data[FIFO_WIDTH-1:WIDTH_BITS]] = pop_data[WIDTH_BITS-1:0];
    end
    if (xfer) begin
      sync_d = hold_q;
      pend_d = 1'b0;
    end
    // Comparators
    for (int i = 0; i < CHANNELS; i++) begin
      pwm_d[i] = en_q && (test_q ? mask_q[i] : (cnt_q < sync_q[i]));
    end
  end

  // Blank or reset clears all core state except blank counter and clock forwarding, outputs low
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      chain_q <= '0;
      frame_q <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        cor_q[i] <= COR_RST;
        hold_q[i] <= '0;
        sync_q[i] <= '0;
      end
      mask_q <= '0;
      pwm_q <= '0;
      cnt_q <= '0;
      idx_q <= '0;
      seq_q <= SEQ_IDLE;
      crd_q <= CRD_RST;
      en_q <= 1'b0;
      test_q <= 1'b0;
      pend_q <= 1'b0;
      async_q <= 1'b0;
      fault_q <= 1'b0;
      pace_q <= 1'b0;
    end else begin
      chain_q <= chain_d;
      frame_q <= frame_d;
      cor_q <= cor_d;
      hold_q <= hold_d;
      sync_q <= sync_d;
      mask_q <= mask_d;
      pwm_q <= pwm_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      seq_q <= seq_d;
      crd_q <= crd_d;
      en_q <= en_d;
      test_q <= test_d;
      pend_q <= pend_d;
      async_q <= async_d;
      fault_q <= fault_d;
      pace_q <= pace_d;
    end
  end

  // Clock forwarding survives blank so the cascade keeps running
  always_ff @(posedge clk_sys) begin
    if (rst) sck_out_q <= 1'b0;
    else sck_out_q <= sck_out_d;
  end

  assign shift_clock_out = sck_out_q;
  assign serial_data_out = chain_q[FRAME_BITS-1];
  assign pwm_out = pwm_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_PWM_CMP: assert property (en_q && !test_q && !blank_act |=>
    pwm_q[0] == ($past(cnt_q) < $past(sync_q[0])))
    else $error("pwm output disagrees with compare");
  AST_CNT_STEP: assert property (pwm_rise && !latch_rise && !blank_act |=>
    cnt_q == WIDTH_BITS'($past(cnt_q) + 1'b1))
    else $error("pwm counter did not advance");
  AST_SDO_LAST: assert property (sck_rise && !latch_lv && !blank_act |=>
    serial_data_out == $past(chain_q[FRAME_BITS-2]))
    else $error("serial out is not last stage");
  AST_SHIFT_CLOCK_OUT: assert property (sck_rise |-> ##2 shift_clock_out)
    else $error("shift clock not forwarded");
  AST_NOCOR: assert property (push_vld && crd_q |-> push_w == push_raw)
    else $error("disabled correction altered width");
  AST_STATUS: assert property (latch_lv && !blank_act |=>
    chain_q[ST_OUT_EN] == $past(en_q) && chain_q[ST_CRD] == $past(crd_q))
    else $error("status not loaded");
  AST_CMD_OE: assert property (latch_rise && cmd == CMD_OUT_ENABLE && !blank_act |=>
    en_q)
    else $error("enable command not decoded");
  AST_BLANK: assert property (blank_act |=> pwm_q == '0 && !en_q)
    else $error("blank did not clear outputs");
  AST_OFF: assert property (!en_q |=> pwm_q == '0)
    else $error("output high while disabled");
  AST_FAULT: assert property (!fault_n_lv && !blank_act |=> fault_q)
    else $error("fault not flagged");
  AST_SYNC_HOLD: assert property (pend_q && cnt_q != '0 && seq_q == SEQ_IDLE && !latch_rise
    && !blank_act |=> sync_q[0] == $past(sync_q[0]))
    else $error("sync update outside period start");

  COV_XFER: cover property (xfer);
  COV_FULL: cover property (push_vld && !push_rdy);
  COV_BLANK: cover property (blank_act);
  COV_TEST: cover property (test_q && en_q);
endmodule : csp_top
`default_nettype wire

//--- hdl/csp_pkg.sv
// Shared constants and types for the cascaded serial PWM latch control block
package csp_pkg;
  // Frame layout
  localparam int CHANNELS = 48;
  localparam int WIDTH_BITS = 12;
  localparam int CMD_BITS = 8;
  localparam int CMD_LSB = 0;
  localparam int FRAME_BITS = CHANNELS * WIDTH_BITS + CMD_BITS;
  localparam int COR_BITS = 6;
  localparam int IDX_BITS = 6;
  // Correction: x * (2/3) * (c + 32) / 64 == x * (c + 32) / 96
  localparam int COR_OFFSET = 32;
  localparam int COR_DIVISOR = 96;
  // Command codes
  localparam logic [7:0] CMD_UPD_SYNC = 8'h00;
  localparam logic [7:0] CMD_UPD_ASYNC = 8'h10;
  localparam logic [7:0] CMD_CORRECTION = 8'h20;
  localparam logic [7:0] CMD_OUT_ENABLE = 8'h30;
  localparam logic [7:0] CMD_SELF_TEST = 8'h60;
  localparam logic [3:0] CMD_COR_TOGGLE_HI = 4'h7;
  // Status byte bit positions
  localparam int ST_FAULT = 7;
  localparam int ST_CRD = 6;
  localparam int ST_OUT_EN = 5;
  localparam int ST_TEST = 4;
  // Reset values
  localparam logic CRD_RST = 1'b0;
  localparam logic [COR_BITS-1:0] COR_RST = 6'h00;
  // Timing
  localparam int CLK_NS = 10;
  localparam int BLANK_NS = 50000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = IDX_BITS + WIDTH_BITS;
  // Correction sequencer
  typedef enum {SEQ_IDLE, SEQ_CALC, SEQ_DRAIN} csp_seq_t;
endpackage : csp_pkg

//--- hdl/csp_sync.sv
// Two-flop synchroniser with rising-edge detect on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Asynchronous input
  input wire logic d,
  // Synchronised level and edge
  output logic lv,
  output logic rise
);
  logic meta_q, meta_d, lv_q, lv_d, prev_q, prev_d;

  // First flop feeds only the second one
  always_comb begin
    meta_d = d;
    lv_d = meta_q;
    prev_d = lv_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= RST_VAL;
      lv_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      lv_q <= lv_d;
      prev_q <= prev_d;
    end
  end

  assign lv = lv_q;
  assign rise = lv_q & ~prev_q;
endmodule : csp_sync
`default_nettype wire

//--- hdl/csp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module csp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fill side
  input wire logic in_vld,
  output logic in_rdy,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_vld,
  input wire logic out_rdy,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty;

  // Extra pointer bit tells full from empty
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign in_rdy = ~full;
  assign out_vld = ~empty;
  assign out_data = mem_q[rp_q[AW-1:0]];

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (in_vld && !full) wp_d = wp_q + 1'b1;
    if (out_rdy && !empty) rp_d = rp_q + 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage needs no reset; pointers guard it
  always_ff @(posedge clk_sys) begin
    if (in_vld && !full) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule : csp_fifo
`default_nettype wire

//--- testbench/csp_host_model.sv
// Host controller model: shifts frames in, pulses the latch, collects the returned chain
`timescale 1ns/1ps
`default_nettype none
module csp_host_model
  import csp_pkg::*;
(
  // System clock that paces every pin change
  input wire logic clk_sys,
  // Serial link toward the block
  output logic shift_clock_in,
  output logic serial_data_in,
  output logic latch_blank_pin,
  // Returned chain
  input wire logic serial_data_out
);
  // Clock and latch stand low outside frames
  initial begin
    shift_clock_in = 1'b0;
    serial_data_in = 1'b0;
    latch_blank_pin = 1'b0;
  end

  // Bits go MSB first at 80 ns each; the latch then stays high for hold cycles
  task automatic send(input logic [FRAME_BITS-1:0] f, input int hold,
                      output logic [FRAME_BITS-1:0] rx);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      serial_data_in <= f[i];
      repeat (4) @(posedge clk_sys);
      rx = {rx[FRAME_BITS-2:0], serial_data_out}; // Taken before the rise
      shift_clock_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      shift_clock_in <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    latch_blank_pin <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    latch_blank_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    serial_data_in <= ~serial_data_in; // Stale data bit is not to be trusted
    @(posedge clk_sys); // Next frame may start without a second write in this step
  endtask : send
endmodule : csp_host_model
`default_nettype wire

//--- testbench/csp_top_tb_top.sv
// Self-checking bench for the cascaded serial PWM block
`timescale 1ns/1ps
`default_nettype none
module csp_top_tb_top
  import csp_pkg::*;
;
  // Short blank time keeps the run brief
  localparam int BLANK_SIM = 40;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pwm_clock_in = 1'b0;
  logic string_fault_n = 1'b1;
  logic shift_clock_in, serial_data_in, latch_blank_pin;
  logic shift_clock_out, serial_data_out;
  logic [CHANNELS-1:0] pwm_out;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [11:0] wexp [CHANNELS];
  logic [11:0] cnt = 12'h000;
  logic [2:0] sck_hist = 3'h0;
  logic [FRAME_BITS-1:0] rx;

  always #5 clk_sys = ~clk_sys;

  csp_top #(.BLANK_CYCLES(BLANK_SIM), .DEPTH(FIFO_DEPTH)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .shift_clock_in(shift_clock_in),
    .serial_data_in(serial_data_in), .latch_blank_pin(latch_blank_pin),
    .shift_clock_out(shift_clock_out), .serial_data_out(serial_data_out),
    .pwm_clock_in(pwm_clock_in), .string_fault_n(string_fault_n), .pwm_out(pwm_out));
  csp_host_model u_host (
    .clk_sys(clk_sys), .shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in),
    .latch_blank_pin(latch_blank_pin), .serial_data_out(serial_data_out));

  task automatic cmp_pwm(input logic [CHANNELS-1:0] got, input logic [CHANNELS-1:0] exp,
                         input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_pwm

  task automatic cmp_fld(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_fld

  // Forwarded clock trails the pin by the three-stage sampling path
  always @(posedge clk_sys) sck_hist <= {sck_hist[1:0], shift_clock_in};
  always @(negedge clk_sys) if (!rst) cmp_fld({11'h0, shift_clock_out}, {11'h0, sck_hist[2]}, "clock copy");

  // Frame kinds: 0 scale values, 1 small widths, 2 large widths, else test mask
  function automatic logic [FRAME_BITS-1:0] mk(input int kind, input logic [7:0] cmd);
    logic [FRAME_BITS-1:0] f;
    f = '0;
    for (int n = 1; n <= CHANNELS; n++) begin
      case (kind)
        0: f[8+12*(n-1) +: 12] = 12'(n - 1);
        1: f[8+12*(n-1) +: 12] = 12'(3 * n);
        2: f[8+12*(n-1) +: 12] = 12'(200 + n);
        default: f[8+12*(n-1) +: 12] = n[0] ? 12'h800 : 12'h000;
      endcase
    end
    f[7:0] = cmd;
    return f;
  endfunction : mk

  // Width = field * 2/3 * (scale + 32) / 64 with scale n-1, or the field as sent
  task automatic set_exp(input int kind, input bit scaled);
    for (int n = 1; n <= CHANNELS; n++) begin
      if (kind == 1) wexp[n-1] = 12'((3 * n) * 2 * (n - 1 + 32) / 192);
      else if (scaled) wexp[n-1] = 12'((200 + n) * 2 * (n - 1 + 32) / 192);
      else wexp[n-1] = 12'(200 + n);
    end
  endtask : set_exp

  function automatic logic [CHANNELS-1:0] exp_vec();
    for (int i = 0; i < CHANNELS; i++) exp_vec[i] = cnt < wexp[i];
  endfunction : exp_vec

  // PWM clock pulses at 25 MHz; checked ticks wait for counter and output
  task automatic run_ticks(input int n, input bit chk);
    for (int k = 0; k < n; k++) begin
      pwm_clock_in <= 1'b1;
      repeat (2) @(posedge clk_sys);
      pwm_clock_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
      cnt = cnt + 12'h001;
      if (chk) begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) cmp_pwm(pwm_out, exp_vec(), "pwm level");
        @(posedge clk_sys);
      end
    end
  endtask : run_ticks

  task automatic t_reset();
    @(negedge clk_sys) cmp_pwm(pwm_out, '0, "pwm after reset");
    cmp_fld({11'h0, serial_data_out}, 12'h000, "serial out after reset");
    @(posedge clk_sys);
    $display("test reset done");
  endtask : t_reset

  task automatic t_async_enable();
    u_host.send(mk(0, CMD_CORRECTION), 20, rx);
    u_host.send(mk(1, CMD_UPD_ASYNC), 20, rx);
    repeat (150) @(posedge clk_sys);
    @(negedge clk_sys) cmp_pwm(pwm_out, '0, "before enable");
    @(posedge clk_sys);
    u_host.send(mk(1, CMD_OUT_ENABLE), 20, rx);
    cmp_fld({4'h0, rx[7:0]}, 12'h000, "idle status");
    set_exp(1, 1'b1);
    cnt = 12'h000;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) cmp_pwm(pwm_out, exp_vec(), "period start");
    @(posedge clk_sys);
    run_ticks(120, 1'b1);
    $display("test async update and enable done");
  endtask : t_async_enable

  task automatic t_selftest_sync();
    string_fault_n <= 1'b0;
    u_host.send(mk(4, CMD_SELF_TEST), 20, rx);
    string_fault_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) cmp_pwm(pwm_out, {24{2'b01}}, "self test mask");
    @(posedge clk_sys);
    u_host.send(mk(2, CMD_UPD_SYNC), 20, rx);
    cmp_fld({4'h0, rx[7:0]}, 12'h0b0, "status byte");
    for (int n = 1; n <= CHANNELS; n++) cmp_fld(rx[8+12*(n-1) +: 12], wexp[n-1], "returned width");
    repeat (150) @(posedge clk_sys);
    @(negedge clk_sys) cmp_pwm(pwm_out, '0, "held until period start");
    @(posedge clk_sys);
    set_exp(2, 1'b1);
    run_ticks(4096 - 121, 1'b0);
    run_ticks(211, 1'b1);
    $display("test self test and sync update done");
  endtask : t_selftest_sync

  task automatic t_toggle_async();
    // Short fault between frames must still reach the next status byte
    string_fault_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    string_fault_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    u_host.send(mk(1, {CMD_COR_TOGGLE_HI, 4'h5}), 20, rx);
    u_host.send(mk(2, CMD_UPD_ASYNC), 20, rx);
    cmp_fld({4'h0, rx[7:0]}, 12'h0e0, "toggled status");
    set_exp(2, 1'b0);
    repeat (150) @(posedge clk_sys);
    @(negedge clk_sys) cmp_pwm(pwm_out, exp_vec(), "unscaled widths");
    @(posedge clk_sys);
    $display("test toggle and async update done");
  endtask : t_toggle_async

  task automatic t_blank();
    u_host.send(mk(1, CMD_OUT_ENABLE), BLANK_SIM + 40, rx);
    @(negedge clk_sys) cmp_pwm(pwm_out, '0, "blanked");
    @(posedge clk_sys);
    run_ticks(5, 1'b0);
    @(negedge clk_sys) cmp_pwm(pwm_out, '0, "stays off after blank");
    @(posedge clk_sys);
    $display("test blank done");
  endtask : t_blank

  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Watchdog sized well past the roughly 60000 cycles the tests need
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_async_enable();
    t_selftest_sync();
    t_toggle_async();
    t_blank();
    wrap_up();
  end
endmodule : csp_top_tb_top
`default_nettype wire
